// File: bench/rtc_core_chk.sv
`timescale 1ns/1ps
module rtc_core_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       power_fail_in,
  input wire logic       irq_n_out,
  input wire logic       irq_n_oe,
  input wire logic       irq
);
  logic [7:0] ctrl;
  logic [7:0] mask;
  // ----------
  // shadow of control and mask
  // ----------
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      ctrl <= 8'h00;
    else if (wr && addr == 8'h00)
      ctrl <= wdata;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      mask <= 8'h00;
    else if (wr && addr == 8'h02)
      mask <= wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------
  // assertions
  // ----------
  property p_rd_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_ctrl;
    logic [7:0] c;
    (rd && addr == 8'h00, c = ctrl) |=> (rdata & 8'hdc) == (c & 8'hdc);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
  property p_h24;
    rd && addr == 8'h23 && !ctrl[4] |=> !rdata[7];
  endproperty
  a_h24: assert property (p_h24) else $error("pm bit in 24h");
  property p_h12;
    rd && addr == 8'h23 && ctrl[4] |=> rdata[6:0] inside {[7'h01:7'h09], [7'h10:7'h12]};
  endproperty
  a_h12: assert property (p_h12) else $error("bad 12h hour");
  property p_unmapped;
    rd && addr inside {8'h03, 8'h05, 8'h30, 8'hff} |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_masked;
    mask == 8'h00 |-> !irq;
  endproperty
  a_masked: assert property (p_masked) else $error("irq while masked");
  property p_standby;
    power_fail_in [*4] ##0 !mask[0] |-> !irq;
  endproperty
  a_standby: assert property (p_standby) else $error("irq in standby");
  property p_pin;
    irq_n_oe == irq && !irq_n_out;
  endproperty
  a_pin: assert property (p_pin) else $error("irq pin drive");
endmodule

bind rtc_core rtc_core_chk chk (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .power_fail_in(power_fail_in), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq(irq));

// File: bench/rtc_host.sv
`timescale 1ns/1ps
module rtc_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] rdata,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr,
  output logic            rd
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ----------
  // bus cycles
  // ----------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge core_clk);
    d = rdata;
  endtask
  // ----------
  // host routines
  // ----------
  task automatic hour12(output logic pm, output logic [7:0] h);
    rd_reg(8'h23, h);
    pm = h[7];
    h = h & 8'h7f;
  endtask
  task automatic exit_test();
    wr_reg(8'h00, 8'h00);
    for (int k = 0; k < 4; k++)
      wr_reg(8'h20 + k[7:0], 8'h00);
  endtask
  task automatic trim_default();
    wr_reg(8'h10, 8'hd2);
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic       core_clk = 1'b0;
  logic       nrst;
  logic       power_fail_in;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq_n_out;
  logic       irq_n_oe;
  logic       irq;
  logic [7:0] v;
  logic       pm;
  int         err_count = 0;
  int         n_checks = 0;
  int         cyc = 0;
  int         t0;
  int         t1;
  logic [7:0] h24 [4] = '{8'h00, 8'h12, 8'h15, 8'h23};
  logic [7:0] h12 [4] = '{8'h12, 8'h92, 8'h83, 8'h91};
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  rtc_host host (.core_clk(core_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  rtc_core #(.TRIM_PERIOD_CYC(1000)) dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .power_fail_in(power_fail_in), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq(irq));
  // ----------
  // helpers
  // ----------
  task automatic wait_change(input logic [7:0] a, input logic [7:0] old, output logic [7:0] d, output int t);
    d = old;
    for (int k = 0; k < 6000 && d === old; k++)
      host.rd_reg(a, d);
    t = cyc;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #4000000;
    err_count++;
    wrap_up();
  end
  // ----------
  // tests
  // ----------
  initial
  begin
    nrst = 1'b0;
    power_fail_in = 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    host.rd_reg(8'h00, v); `CHK(v, 8'h00)
    host.rd_reg(8'h05, v); `CHK(v, 8'h00)
    host.wr_reg(8'h33, 8'h15);
    for (int i = 0; i < 4; i++)
    begin
      host.wr_reg(8'h00, 8'h00);
      host.wr_reg(8'h23, h24[i]);
      host.rd_reg(8'h23, v); `CHK(v, h24[i])
      host.wr_reg(8'h00, 8'h10);
      host.rd_reg(8'h23, v); `CHK(v, h12[i])
    end
    host.hour12(pm, v); `CHK({pm, v}, 9'h111)
    host.rd_reg(8'h33, v); `CHK(v, 8'h15)
    host.exit_test();
    host.rd_reg(8'h23, v); `CHK(v, 8'h00)
    host.wr_reg(8'h10, 8'hff);
    host.wr_reg(8'h21, 8'h59);
    host.wr_reg(8'h00, 8'hc0);
    repeat (10000) @(posedge core_clk);
    host.rd_reg(8'h21, v); `CHK(v, 8'h59)
    host.wr_reg(8'h00, 8'hc8);
    wait_change(8'h21, 8'h59, v, t0); `CHK(v, 8'h00)
    host.rd_reg(8'h22, v); `CHK(v, 8'h01)
    host.rd_reg(8'h23, v); `CHK(v, 8'h01)
    wait_change(8'h21, 8'h00, v, t1); `CHK((t1 - t0) inside {[7700:7900]}, 1'b1)
    host.trim_default();
    host.rd_reg(8'h10, v); `CHK(v, 8'hd2)
    host.exit_test();
    host.wr_reg(8'h10, 8'h00);
    repeat (2000) @(posedge core_clk);
    host.wr_reg(8'h20, 8'h99);
    host.wr_reg(8'h00, 8'h40);
    wait_change(8'h20, 8'h99, v, t0); `CHK(v, 8'h00)
    host.rd_reg(8'h21, v); `CHK(v, 8'h01)
    wait_change(8'h20, 8'h00, v, t1); `CHK((t1 - t0) inside {[7700:7900]}, 1'b1)
    host.exit_test();
    host.wr_reg(8'h10, 8'hff);
    repeat (2000) @(posedge core_clk);
    host.wr_reg(8'h00, 8'h40);
    repeat (12000) @(posedge core_clk);
    host.rd_reg(8'h20, v); `CHK(v, 8'h00)
    host.exit_test();
    power_fail_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    power_fail_in <= 1'b0;
    host.wr_reg(8'h31, 8'h01);
    host.wr_reg(8'h32, 8'hff);
    host.wr_reg(8'h33, 8'hff);
    host.wr_reg(8'h21, 8'h01);
    host.wr_reg(8'h02, 8'h01);
    host.wr_reg(8'h00, 8'hcc);
    for (int i = 0; i < 20000 && irq !== 1'b1; i++)
      @(posedge core_clk);
    host.wr_reg(8'h00, 8'h00);
    power_fail_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(irq_n_oe, 1'b1)
    power_fail_in <= 1'b0;
    host.wr_reg(8'h02, 8'h00);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    host.wr_reg(8'h02, 8'h01);
    @(posedge core_clk);
    `CHK(irq, 1'b1)
    host.rd_reg(8'h01, v); `CHK(v[0], 1'b1)
    host.wr_reg(8'h01, 8'h01);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    host.rd_reg(8'h01, v); `CHK(v[0], 1'b0)
    wrap_up();
  end
endmodule

// File: src/rtc_bcd_field.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"

// one bcd counter field with load, increment and wrap
module rtc_bcd_field #(
  parameter logic [7:0] LAST = 8'h59
)(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       inc,
  output logic [7:0]      value,
  output logic            wrap
);

  logic [7:0] next_value;

  always_comb
  begin
    if (value == LAST)
      next_value = 8'h00;
    else if (value[3:0] == 4'h9)
      next_value = {value[7:4] + 4'h1, 4'h0};
    else
      next_value = {value[7:4], value[3:0] + 4'h1};
  end

  assign wrap = inc && (value == LAST);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      value <= 8'h00;
    else if (load)
      value <= load_val;
    else if (inc)
      value <= next_value;
  end

endmodule

// File: src/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STAT        8'h01
`define REG_MASK        8'h02
`define REG_TRIM        8'h10
`define REG_HSEC        8'h20
`define REG_SEC         8'h21
`define REG_MIN         8'h22
`define REG_HOUR        8'h23
`define REG_ALM_SEC     8'h31
`define REG_ALM_MIN     8'h32
`define REG_ALM_HOUR    8'h33

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define CTRL_ALM_EN     2
`define CTRL_PAR_EN     3
`define CTRL_H12        4
`define CTRL_TEST0      6
`define CTRL_TEST1      7
`define CTRL_RESET      8'h00
`define HOUR_PM         7

// ---------------------------------------------------------------
// status bits
// ---------------------------------------------------------------
`define ST_ALARM        0
`define ST_TICK         1
`define STAT_RESET      8'h00
`define TRIM_RESET      8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ          25000000
`define OSC_HZ          32768
`define TRIM_PERIOD_S   31
`define RATE_100_HZ     100
`define RATE_3K2_HZ     3200
`define ACCEL           32

`endif

// File: src/rtc_core.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rtc_core
#(
  parameter int unsigned TRIM_PERIOD_CYC = `CLK_HZ * `TRIM_PERIOD_S
)(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic       power_fail_in,
  output logic            irq_n_out,
  output logic            irq_n_oe,
  output logic            irq
);
  import rtc_pkg::*;

  // ---------------------------------------------------------------
  // registers and synchroniser
  // ---------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] stat;
  logic [7:0] mask;
  logic [7:0] trim;
  logic [7:0] alm_sec;
  logic [7:0] alm_min;
  logic [7:0] alm_hour;
  logic [7:0] hour24;
  logic       pf_meta;
  logic       pf_sync;
  mode_type   mode;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
    end
    else
    begin
      pf_meta <= power_fail_in;
      pf_sync <= pf_meta;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb
  begin
    case ({ctrl[`CTRL_TEST1], ctrl[`CTRL_TEST0]})
      2'b00:   mode = mode_normal;
      2'b01:   mode = mode_accel;
      2'b10:   mode = mode_par_slow;
      2'b11:   mode = mode_par_fast;
      default: mode = mode_normal;
    endcase
  end

  // ---------------------------------------------------------------
  // tick generation and trimming
  // ---------------------------------------------------------------
  localparam logic [31:0] MOD_CLK  = 32'(`CLK_HZ);
  localparam logic [31:0] STEP_N   = 32'(`RATE_100_HZ);
  localparam logic [31:0] STEP_A   = 32'(`RATE_100_HZ * `ACCEL);
  localparam logic [31:0] STEP_P   = 32'(`RATE_3K2_HZ);
  localparam logic [31:0] OSC_STEP = 32'(`OSC_HZ);

  logic [31:0] tick_step;
  logic        tick_raw;
  logic        osc_tick;
  logic        tick;
  logic [31:0] trim_cnt;
  logic [7:0]  trim_left;
  logic        swallow;
  logic        trim_act;

  always_comb
  begin
    case (mode)
      mode_normal:   tick_step = STEP_N;
      mode_accel:    tick_step = STEP_A;
      mode_par_slow: tick_step = STEP_N;
      mode_par_fast: tick_step = STEP_P;
      default:       tick_step = STEP_N;
    endcase
  end

  rtc_rate_div u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .step     (tick_step),
    .modulus  (MOD_CLK),
    .tick     (tick_raw)
  );

  rtc_rate_div u_osc (
    .core_clk (core_clk),
    .nrst     (nrst),
    .step     (OSC_STEP),
    .modulus  (MOD_CLK),
    .tick     (osc_tick)
  );

  assign trim_act = !ctrl[`CTRL_TEST1];
  assign swallow  = trim_act && (trim_left != 8'h00) && osc_tick;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trim_cnt  <= 32'h0000_0000;
      trim_left <= 8'h00;
    end
    else if (trim_cnt == TRIM_PERIOD_CYC - 1)
    begin
      trim_cnt  <= 32'h0000_0000;
      trim_left <= trim;
    end
    else
    begin
      trim_cnt <= trim_cnt + 32'h0000_0001;
      if (swallow)
        trim_left <= trim_left - 8'h01;
    end
  end

  // a swallowed oscillator pulse holds back the next time tick
  logic owed;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      owed <= 1'b0;
    else if (swallow && !tick_raw)
      owed <= 1'b1;
    else if (tick_raw && !swallow)
      owed <= 1'b0;
  end
  assign tick = tick_raw && !owed && !swallow;

  // ---------------------------------------------------------------
  // clock fields
  // ---------------------------------------------------------------
  logic        par;
  logic [7:0]  hsec;
  logic [7:0]  sec;
  logic [7:0]  min;
  logic        w_hsec;
  logic        w_sec;
  logic        w_min;
  logic        wr_hour;
  logic [7:0]  hour_in24;
  logic [7:0]  hour_rd;

  assign par = ctrl[`CTRL_TEST1];

  rtc_bcd_field #(.LAST(8'h99)) u_hsec (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (wr && addr == `REG_HSEC),
    .load_val (wdata),
    .inc      (tick && (!par || ctrl[`CTRL_PAR_EN])),
    .value    (hsec),
    .wrap     (w_hsec)
  );

  rtc_bcd_field #(.LAST(8'h59)) u_sec (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (wr && addr == `REG_SEC),
    .load_val (wdata),
    .inc      (par ? (tick && ctrl[`CTRL_PAR_EN]) : w_hsec),
    .value    (sec),
    .wrap     (w_sec)
  );

  rtc_bcd_field #(.LAST(8'h59)) u_min (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (wr && addr == `REG_MIN),
    .load_val (wdata),
    .inc      (par ? (tick && ctrl[`CTRL_PAR_EN]) : w_sec),
    .value    (min),
    .wrap     (w_min)
  );

  // bcd 12 hour <-> 24 hour helpers
  function automatic logic [7:0] to24(input logic [7:0] h12);
    logic [7:0] h;
    h = {1'b0, h12[6:0]};
    if (h12[`HOUR_PM])
      to24 = (h == 8'h12) ? 8'h12 : ((h[3:0] >= 4'h8) ? h + 8'h18 : h + 8'h12);
    else
      to24 = (h == 8'h12) ? 8'h00 : h;
  endfunction

  function automatic logic [7:0] to12(input logic [7:0] h24);
    logic [7:0] h;
    h = h24;
    if (h24 == 8'h00)
      to12 = 8'h12;
    else if (h24 < 8'h12)
      to12 = h;
    else if (h24 == 8'h12)
      to12 = 8'h92;
    else
      to12 = ((h[3:0] < 4'h2) ? h - 8'h18 : h - 8'h12) | 8'h80;
  endfunction

  // hours kept in 24 hour bcd, so a format change converts with no extra step
  assign wr_hour   = wr && addr == `REG_HOUR;
  assign hour_in24 = ctrl[`CTRL_H12] ? to24(wdata) : {1'b0, wdata[6:0]};
  assign hour_rd   = ctrl[`CTRL_H12] ? to12(hour24) : {1'b0, hour24[6:0]};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hour24 <= 8'h00;
    else if (wr_hour)
      hour24 <= hour_in24;
    else if (par ? (tick && ctrl[`CTRL_PAR_EN]) : w_min)
      hour24 <= (hour24 == 8'h23) ? 8'h00 :
                ((hour24[3:0] == 4'h9) ? {hour24[7:4] + 4'h1, 4'h0} : hour24 + 8'h01);
  end

  // ---------------------------------------------------------------
  // alarm compare, ff acts as wildcard
  // ---------------------------------------------------------------
  logic alarm_hit;
  assign alarm_hit = ctrl[`CTRL_ALM_EN] && tick && (hsec == 8'h00) &&
                     (alm_sec  == 8'hff || alm_sec  == sec) &&
                     (alm_min  == 8'hff || alm_min  == min) &&
                     (alm_hour == 8'hff || alm_hour == hour_rd);

  // ---------------------------------------------------------------
  // control, trim, alarm and mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl     <= `CTRL_RESET;
      trim     <= `TRIM_RESET;
      mask     <= 8'h00;
      alm_sec  <= 8'hff;
      alm_min  <= 8'hff;
      alm_hour <= 8'hff;
    end
    else
    begin
      if (wr && addr == `REG_CTRL)
        ctrl <= wdata;
      if (wr && addr == `REG_TRIM)
        trim <= wdata;
      if (wr && addr == `REG_MASK)
        mask <= wdata;
      if (wr && addr == `REG_ALM_SEC)
        alm_sec <= wdata;
      if (wr && addr == `REG_ALM_MIN)
        alm_min <= wdata;
      if (wr && addr == `REG_ALM_HOUR)
        alm_hour <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // status, set wins over write-one-to-clear
  // ---------------------------------------------------------------
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  always_comb
  begin
    set_bits = 8'h00;
    set_bits[`ST_ALARM] = alarm_hit;
    set_bits[`ST_TICK]  = tick && !pf_sync;
    clr_bits = (wr && addr == `REG_STAT) ? wdata : 8'h00;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      stat <= `STAT_RESET;
    else
      stat <= (stat & ~clr_bits) | set_bits;
  end

  // standby passes only the alarm source
  logic [7:0] pend;
  assign pend      = stat & mask & (pf_sync ? 8'h01 : 8'hff);
  assign irq       = |pend;
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = irq;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `REG_CTRL:     rdata <= ctrl;
        `REG_STAT:     rdata <= stat;
        `REG_MASK:     rdata <= mask;
        `REG_TRIM:     rdata <= trim;
        `REG_HSEC:     rdata <= hsec;
        `REG_SEC:      rdata <= sec;
        `REG_MIN:      rdata <= min;
        `REG_HOUR:     rdata <= hour_rd;
        `REG_ALM_SEC:  rdata <= alm_sec;
        `REG_ALM_MIN:  rdata <= alm_min;
        `REG_ALM_HOUR: rdata <= alm_hour;
        default:       rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule

// File: src/rtc_pkg.sv
package rtc_pkg;
  typedef enum logic [3:0]
  {
    mode_normal   = 4'b0001,
    mode_accel    = 4'b0010,
    mode_par_slow = 4'b0100,
    mode_par_fast = 4'b1000
  } mode_type;
endpackage

// File: src/rtc_rate_div.sv
`timescale 1ns/1ps
`include "rtc_cfg.svh"

// fractional divider: one-cycle pulse at step/modulus of core_clk
module rtc_rate_div #(
  parameter int unsigned W = 32
)(
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] step,
  input  wire logic [W-1:0] modulus,
  output logic              tick
);

  logic [W-1:0] acc;
  logic [W:0]   sum;

  assign sum = {1'b0, acc} + {1'b0, step};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc  <= '0;
      tick <= 1'b0;
    end
    else if (sum >= {1'b0, modulus})
    begin
      acc  <= W'(sum - {1'b0, modulus});
      tick <= 1'b1;
    end
    else
    begin
      acc  <= sum[W-1:0];
      tick <= 1'b0;
    end
  end

endmodule
